// *** verilog/tlc_pkg.sv ***
// Overview of operation
// R1: eight 6-bit pulse-shape registers reload defaults on every configuration write.
// R2: each configuration write copies ROM defaults for the chosen template into shapes.
// R3: during the copy, configuration accesses may be ignored or read back wrong.
// R4: host waits eight master clocks after a configuration write before touching it.
// R5: ratio bit: 0 selects 1:1.36, 1 selects 1:1.15; reduced amplitude with termination.
// R6: termination bit: 0 internal impedance, 1 external termination resistor present.
// R7: build-out field gives 0.0, 7.5, 15.0 or 22.5 dB attenuation; the code applies it with the long-haul template only, else 0.0 dB.
// R8: template codes 000-100 short-haul T1, 101 E1 coax, 110 E1 pair, 111 long-haul.
// R9: auto switching plus transmit clock loss: alternate clock and all-ones data.
// R10: auto switching plus forced alarm: all-ones on alternate clock regardless of loss.
// R11: host enables auto switching only with a valid clock on the alternate input.
// R12: writes to reserved bits have no effect; they read as zero.
// R13: no forced alarm: all-ones on primary clock for receive loss when auto alarm set.
// R14: switching between primary and alternate transmit clocks is glitch and runt free.
package tlc_pkg;
   // register port
   localparam int TLC_ADDR_W = 9;
   localparam logic [8:0] TLC_SHAPE_BASE = 9'h060;
   localparam logic [8:0] TLC_CFG_ADDR = 9'h068;
   localparam int TLC_SHAPE_NUM = 8;
   localparam int TLC_COEF_W = 6;
   localparam int TLC_COPY_CYCLES = 8;
   // configuration field positions
   localparam int TLC_TURNS_BIT = 7;
   localparam int TLC_TERM_BIT = 6;
   localparam int TLC_LBO_LSB = 4;
   localparam int TLC_PULSE_LSB = 1;
   localparam int TLC_AUTO_ALT_CLK_BIT = 0;
   // reset values
   localparam logic [7:0] TLC_CFG_RST = 8'h00;
   localparam logic [5:0] TLC_SHAPE_RST = 6'h00;
   // build-out step in tenths of a dB
   localparam logic [7:0] TLC_LBO_STEP_TENTH_DB = 8'h4B;
   // pulse template codes
   localparam logic [2:0] TLC_PULSE_SH_MAX = 3'h4;
   localparam logic [2:0] TLC_PULSE_E1_COAX = 3'h5;
   localparam logic [2:0] TLC_PULSE_E1_PAIR = 3'h6;
   localparam logic [2:0] TLC_PULSE_T1_LONG = 3'h7;
   typedef enum logic {TLC_IDLE, TLC_COPY} tlc_state_e;
endpackage : tlc_pkg

// *** verilog/tlc_shape_rom.sv ***
`timescale 1ns/1ns
`default_nettype none
module tlc_shape_rom
   import tlc_pkg::*;
#(
   // default coefficient image, arbitrary values, template 7 in the top word
   parameter logic [383:0] ROM_IMAGE = {
      48'h1F3E_7C1F_3E7C, 48'h2A54_A82A_54A8, 48'h0C18_300C_1830, 48'h3366_CC33_66CC,
      48'h1122_4488_1122, 48'h2D5A_B42D_5AB4, 48'h0F1E_3C0F_1E3C, 48'h3C78_F03C_78F0}
)(
   input wire logic [2:0] template_sel,
   input wire logic [2:0] coef_index,
   output logic [5:0] coef_data
);
   // pure lookup; the copy sequencer owns the timing
   always_comb begin
      coef_data = ROM_IMAGE[{template_sel, coef_index, 3'h0} - {template_sel, coef_index, 1'b0} +: 6];
   end
endmodule : tlc_shape_rom
`default_nettype wire

// *** verilog/tlc_clk_mux.sv ***
`timescale 1ns/1ns
`default_nettype none
module tlc_clk_mux
   import tlc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic resetn,
   input wire logic primary_tx_line_clk,
   input wire logic alt_ref_line_clk,
   input wire logic use_alt,
   output logic tx_clk_out
);
   logic [1:0] sync1_reg;
   logic [1:0] sync2_reg;
   logic [1:0] sync3_reg;
   logic cur_alt_reg;
   logic cur_alt_next;
   logic out_reg;
   logic out_next;
   // two-stage synchronisers, one per line clock pin
   genvar gi;
   generate
      for (gi = 0; gi < 2; gi++) begin : g_sync
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               sync1_reg[gi] <= 1'b0;
               sync2_reg[gi] <= 1'b0;
               sync3_reg[gi] <= 1'b0;
            end else begin
               sync1_reg[gi] <= (gi == 0) ? primary_tx_line_clk : alt_ref_line_clk;
               sync2_reg[gi] <= sync1_reg[gi];
               sync3_reg[gi] <= sync2_reg[gi]; // edge history, not a sync stage
            end
         end
      end
   endgenerate
   // switch at a falling edge of the new source while the output is low: the low phase
   // then spans a whole low half of the new source, so no runt; may wait one period
   always_comb begin
      cur_alt_next = cur_alt_reg;
      if (use_alt != cur_alt_reg && !out_reg && !sync2_reg[cur_alt_reg]
            && sync3_reg[use_alt] && !sync2_reg[use_alt]) begin // R14
         cur_alt_next = use_alt;
      end
      out_next = cur_alt_next ? sync2_reg[1] : sync2_reg[0];
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         cur_alt_reg <= 1'b0;
         out_reg <= 1'b0;
      end else begin
         cur_alt_reg <= cur_alt_next;
         out_reg <= out_next;
      end
   end
   assign tx_clk_out = out_reg;
   property p_switch_in_low;
      @(posedge ref_clk) disable iff (!resetn)
         (cur_alt_reg != $past(cur_alt_reg)) |-> !$past(out_reg) && !out_reg;
   endproperty
   a_switch_in_low: assert property (p_switch_in_low) else $error("clock switched while high"); // R14
endmodule : tlc_clk_mux
`default_nettype wire

// *** verilog/tlc_top.sv ***
`timescale 1ns/1ns
`default_nettype none
module tlc_top
   import tlc_pkg::*;
#(
   parameter int ADDR_W = TLC_ADDR_W,
   parameter int SHAPE_NUM = TLC_SHAPE_NUM,
   parameter int COEF_W = TLC_COEF_W
)(
   input wire logic ref_clk,
   input wire logic resetn,
   // parallel register port, synchronous to ref_clk
   input wire logic [ADDR_W-1:0] cpu_addr,
   input wire logic cpu_wr_en,
   input wire logic cpu_rd_en,
   input wire logic [7:0] cpu_wdata,
   output logic [7:0] cpu_rdata,
   // alarm controls from the transmit alarm register, same clock
   input wire logic force_all_ones_tx,
   input wire logic auto_all_ones_on_rx_loss,
   // status from the clock and signal monitors, asynchronous
   input wire logic tx_clock_lost,
   input wire logic rx_signal_or_clock_lost,
   // line clocks, asynchronous pins
   input wire logic primary_tx_line_clk,
   input wire logic alt_ref_line_clk,
   // transmit line controls
   output logic tx_clk_out,
   output logic tx_use_alt_clk,
   output logic tx_send_all_ones,
   output logic ratio_1_15_sel,
   output logic ext_term_sel,
   output logic amp_reduced,
   output logic [1:0] build_out_sel,
   output logic [7:0] build_out_atten,
   output logic [2:0] pulse_template,
   output logic pulse_short_t1,
   output logic pulse_e1,
   output logic pulse_long_t1,
   output logic shape_busy,
   output logic [SHAPE_NUM*COEF_W-1:0] shape_coeffs
);
   // elaboration check: the ROM and field layout are built for these sizes
   generate
      if (SHAPE_NUM != TLC_SHAPE_NUM || COEF_W != TLC_COEF_W || ADDR_W < TLC_ADDR_W) begin : g_chk
         $error("tlc_top: unsupported SHAPE_NUM, COEF_W or ADDR_W");
      end
   endgenerate

   tlc_state_e state_reg;
   tlc_state_e state_next;
   logic [2:0] cnt_reg;
   logic [2:0] cnt_next;
   logic [7:0] cfg_reg;
   logic [7:0] cfg_next;
   logic [COEF_W-1:0] shape_reg [SHAPE_NUM];
   logic [COEF_W-1:0] shape_next [SHAPE_NUM];
   logic [7:0] rdata_reg;
   logic [7:0] rdata_next;
   logic [1:0] stat_sync1_reg;
   logic [1:0] stat_sync2_reg;
   logic alt_reg;
   logic alt_next;
   logic ones_reg;
   logic ones_next;
   logic [5:0] rom_data;
   logic cfg_hit;
   logic shape_hit;
   logic [2:0] shape_idx;
   logic tx_lost_s;
   logic rx_lost_s;
   logic auto_alt_clk_switch;

   assign cfg_hit = (cpu_addr == ADDR_W'(TLC_CFG_ADDR));
   assign shape_hit = (cpu_addr >= ADDR_W'(TLC_SHAPE_BASE))
                   && (cpu_addr < ADDR_W'(TLC_SHAPE_BASE) + ADDR_W'(SHAPE_NUM));
   assign shape_idx = 3'(cpu_addr - ADDR_W'(TLC_SHAPE_BASE));
   assign auto_alt_clk_switch = cfg_reg[TLC_AUTO_ALT_CLK_BIT];

   // default coefficient lookup for the stored template, walked by the copy counter
   tlc_shape_rom u_rom (
      .template_sel(cfg_reg[TLC_PULSE_LSB +: 3]),
      .coef_index(cnt_reg),
      .coef_data(rom_data)
   );

   // configuration register and copy sequencer
   always_comb begin
      state_next = state_reg;
      cnt_next = cnt_reg;
      cfg_next = cfg_reg;
      unique case (state_reg)
         TLC_IDLE: begin
            if (cpu_wr_en && cfg_hit) begin // R2
               cfg_next = cpu_wdata;
               state_next = TLC_COPY;
               cnt_next = 3'h0;
            end
         end
         TLC_COPY: begin
            // writes land nowhere while the copy runs, so the template cannot shift mid-copy
            cnt_next = cnt_reg + 3'h1; // R3
            if (cnt_reg == 3'(TLC_COPY_CYCLES - 1)) begin
               state_next = TLC_IDLE;
            end
         end
      endcase
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= TLC_IDLE;
         cnt_reg <= 3'h0;
         cfg_reg <= TLC_CFG_RST;
      end else begin
         state_reg <= state_next;
         cnt_reg <= cnt_next;
         cfg_reg <= cfg_next;
      end
   end

   // shape registers: ROM copy has priority, host writes only when idle
   always_comb begin
      for (int i = 0; i < SHAPE_NUM; i++) begin
         shape_next[i] = shape_reg[i];
      end
      if (state_reg == TLC_COPY) begin
         shape_next[cnt_reg] = rom_data; // R1
      end else if (cpu_wr_en && shape_hit) begin
         shape_next[shape_idx] = cpu_wdata[COEF_W-1:0]; // R12
      end
   end
   genvar gs;
   generate
      for (gs = 0; gs < SHAPE_NUM; gs++) begin : g_shape
         always_ff @(posedge ref_clk or negedge resetn) begin
            if (!resetn) begin
               shape_reg[gs] <= TLC_SHAPE_RST;
            end else begin
               shape_reg[gs] <= shape_next[gs];
            end
         end
         assign shape_coeffs[gs*COEF_W +: COEF_W] = shape_reg[gs];
      end
   endgenerate

   // read data, one cycle after the strobe; unmapped addresses read zero
   always_comb begin
      rdata_next = rdata_reg;
      if (cpu_rd_en) begin
         rdata_next = 8'h00;
         if (cfg_hit) begin
            rdata_next = cfg_reg;
         end else if (shape_hit) begin
            rdata_next = {2'h0, shape_reg[shape_idx]}; // R12
         end
      end
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         rdata_reg <= 8'h00;
      end else begin
         rdata_reg <= rdata_next;
      end
   end
   assign cpu_rdata = rdata_reg;

   // monitor status crosses from outside, two stages before use
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         stat_sync1_reg <= 2'h0;
         stat_sync2_reg <= 2'h0;
      end else begin
         stat_sync1_reg <= {rx_signal_or_clock_lost, tx_clock_lost};
         stat_sync2_reg <= stat_sync1_reg;
      end
   end
   assign tx_lost_s = stat_sync2_reg[0];
   assign rx_lost_s = stat_sync2_reg[1];

   // clock source and alarm data selection
   always_comb begin
      alt_next = auto_alt_clk_switch && (force_all_ones_tx || tx_lost_s); // R9 R10
      ones_next = force_all_ones_tx // R10
               || (auto_alt_clk_switch && tx_lost_s) // R9
               || (auto_all_ones_on_rx_loss && rx_lost_s); // R13
   end
   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         alt_reg <= 1'b0;
         ones_reg <= 1'b0;
      end else begin
         alt_reg <= alt_next;
         ones_reg <= ones_next;
      end
   end
   assign tx_use_alt_clk = alt_reg;
   assign tx_send_all_ones = ones_reg;

   // glitch-free transmit clock selection
   tlc_clk_mux u_mux (
      .ref_clk(ref_clk),
      .resetn(resetn),
      .primary_tx_line_clk(primary_tx_line_clk),
      .alt_ref_line_clk(alt_ref_line_clk),
      .use_alt(alt_reg), // R14
      .tx_clk_out(tx_clk_out)
   );

   // line driver controls decoded from the stored configuration
   assign ratio_1_15_sel = cfg_reg[TLC_TURNS_BIT]; // R5
   assign ext_term_sel = cfg_reg[TLC_TERM_BIT]; // R6
   // driver is current limited: 1:1.15 with external termination loses height
   assign amp_reduced = cfg_reg[TLC_TURNS_BIT] && cfg_reg[TLC_TERM_BIT]; // R5
   assign build_out_sel = cfg_reg[TLC_LBO_LSB +: 2];
   // attenuation in tenths of a dB; networks only apply to the long-haul template
   assign build_out_atten = pulse_long_t1 ? 8'(build_out_sel * TLC_LBO_STEP_TENTH_DB) : 8'h00; // R7
   assign pulse_template = cfg_reg[TLC_PULSE_LSB +: 3];
   assign pulse_short_t1 = (pulse_template <= TLC_PULSE_SH_MAX); // R8
   assign pulse_e1 = (pulse_template == TLC_PULSE_E1_COAX)
                  || (pulse_template == TLC_PULSE_E1_PAIR); // R8
   assign pulse_long_t1 = (pulse_template == TLC_PULSE_T1_LONG); // R8
   assign shape_busy = (state_reg == TLC_COPY);

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   sequence s_copy_run;
      shape_busy [*8] ##1 !shape_busy;
   endsequence
   property p_cfg_write_copies;
      (cpu_wr_en && cfg_hit && !shape_busy) |=> s_copy_run;
   endproperty
   a_cfg_write_copies: assert property (p_cfg_write_copies) else $error("copy not eight cycles"); // R2
   property p_shape_from_rom;
      shape_busy |=> shape_reg[$past(cnt_reg)] == $past(rom_data);
   endproperty
   a_shape_from_rom: assert property (p_shape_from_rom) else $error("shape not loaded from rom"); // R1
   property p_busy_write_ignored;
      (shape_busy && cpu_wr_en) |=> cfg_reg == $past(cfg_reg);
   endproperty
   a_busy_write_ignored: assert property (p_busy_write_ignored) else $error("write during copy"); // R3
   property p_shape_reserved_zero;
      (cpu_rd_en && shape_hit) |=> cpu_rdata[7:6] == 2'h0;
   endproperty
   a_shape_reserved_zero: assert property (p_shape_reserved_zero) else $error("reserved bits set"); // R12
   property p_auto_switch;
      (auto_alt_clk_switch && tx_lost_s) |=> tx_use_alt_clk && tx_send_all_ones;
   endproperty
   a_auto_switch: assert property (p_auto_switch) else $error("no switch on clock loss"); // R9
   property p_forced_alt;
      (auto_alt_clk_switch && force_all_ones_tx) |=> tx_use_alt_clk && tx_send_all_ones;
   endproperty
   a_forced_alt: assert property (p_forced_alt) else $error("forced alarm not on alternate"); // R10
   property p_rx_loss_primary;
      (!force_all_ones_tx && auto_all_ones_on_rx_loss && rx_lost_s
         && !(auto_alt_clk_switch && tx_lost_s))
         |=> !tx_use_alt_clk && tx_send_all_ones;
   endproperty
   a_rx_loss_primary: assert property (p_rx_loss_primary) else $error("rx loss alarm wrong"); // R13
   property p_normal_data;
      (!force_all_ones_tx && !(auto_all_ones_on_rx_loss && rx_lost_s)
         && !(auto_alt_clk_switch && tx_lost_s))
         |=> !tx_use_alt_clk && !tx_send_all_ones;
   endproperty
   a_normal_data: assert property (p_normal_data) else $error("normal data not sent"); // R13
   property p_status_latency;
      $rose(tx_clock_lost) && auto_alt_clk_switch ##1 tx_clock_lost [*3] |=> tx_use_alt_clk;
   endproperty
   a_status_latency: assert property (p_status_latency) else $error("switch too slow"); // R9

   // host access checks
   property p_cfg_write_lands;
      (cpu_wr_en && cfg_hit && !shape_busy) |=> cfg_reg == $past(cpu_wdata);
   endproperty
   a_cfg_write_lands: assert property (p_cfg_write_lands) else $error("config write lost"); // R2
   property p_shape_host_write;
      (cpu_wr_en && shape_hit && !shape_busy) |=> shape_reg[$past(shape_idx)] == $past(cpu_wdata[COEF_W-1:0]);
   endproperty
   a_shape_host_write: assert property (p_shape_host_write) else $error("shape write lost"); // R12
   property p_unmapped_read_zero;
      (cpu_rd_en && !cfg_hit && !shape_hit) |=> cpu_rdata == 8'h00;
   endproperty
   a_unmapped_read_zero: assert property (p_unmapped_read_zero) else $error("unmapped read"); // R12

   // shape hold, decode and clock source checks
   property p_shape_hold;
      (!shape_busy && !(cpu_wr_en && shape_hit)) |=> $stable(shape_coeffs);
   endproperty
   a_shape_hold: assert property (p_shape_hold) else $error("shapes changed unasked"); // R1
   property p_atten_zero;
      !pulse_long_t1 |-> build_out_atten == 8'h00;
   endproperty
   a_atten_zero: assert property (p_atten_zero) else $error("attenuation off long haul"); // R7
   property p_template_class;
      $onehot({pulse_short_t1, pulse_e1, pulse_long_t1});
   endproperty
   a_template_class: assert property (p_template_class) else $error("template class not one"); // R8
   property p_amp_needs_both;
      amp_reduced |-> ratio_1_15_sel && ext_term_sel;
   endproperty
   a_amp_needs_both: assert property (p_amp_needs_both) else $error("amplitude cut wrongly"); // R5
   property p_no_alt_without_switch;
      !auto_alt_clk_switch |=> !tx_use_alt_clk;
   endproperty
   a_no_alt_without_switch: assert property (p_no_alt_without_switch) else $error("alt clock used"); // R13
endmodule : tlc_top
`default_nettype wire

// *** sim/tlc_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module tlc_host_model
   import tlc_pkg::*;
(
   input wire logic ref_clk,
   output logic [TLC_ADDR_W-1:0] cpu_addr,
   output logic cpu_wr_en,
   output logic cpu_rd_en,
   output logic [7:0] cpu_wdata,
   input wire logic [7:0] cpu_rdata
);
   // quiet bus at time zero
   initial begin
      cpu_addr = '0;
      cpu_wr_en = 1'b0;
      cpu_rd_en = 1'b0;
      cpu_wdata = '0;
   end
   // idle lines show inverted values, so stale data never looks valid
   task automatic write(input logic [8:0] addr, input logic [7:0] data, input logic settle);
      @(posedge ref_clk);
      cpu_addr <= addr;
      cpu_wdata <= data;
      cpu_wr_en <= 1'b1;
      @(posedge ref_clk);
      cpu_wr_en <= 1'b0;
      cpu_addr <= ~addr;
      cpu_wdata <= ~data;
      if (settle && addr == TLC_CFG_ADDR) begin
         repeat (TLC_COPY_CYCLES + 1) @(posedge ref_clk);
      end
   endtask : write
   // data is taken once the registered answer has landed
   task automatic read(input logic [8:0] addr, output logic [7:0] data);
      @(posedge ref_clk);
      cpu_addr <= addr;
      cpu_rd_en <= 1'b1;
      @(posedge ref_clk);
      cpu_rd_en <= 1'b0;
      cpu_addr <= ~addr;
      @(posedge ref_clk);
      #1 data = cpu_rdata;
   endtask : read
endmodule : tlc_host_model
`default_nettype wire

// *** sim/tlc_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(what, exp, got) \
   begin \
      samples_checked++; \
      if ((got) !== (exp)) begin \
         errors++; \
         $display("mismatch %s expected %0h seen %0h", what, exp, got); \
      end \
   end
module tlc_tb
   import tlc_pkg::*;
;
   // same arbitrary image the shape rom holds by default
   localparam logic [383:0] ROM = {
      48'h1F3E_7C1F_3E7C, 48'h2A54_A82A_54A8, 48'h0C18_300C_1830, 48'h3366_CC33_66CC,
      48'h1122_4488_1122, 48'h2D5A_B42D_5AB4, 48'h0F1E_3C0F_1E3C, 48'h3C78_F03C_78F0};
   int errors = 0;
   int samples_checked = 0;
   int run_len = 0;
   int last_run = 0;
   logic ref_clk = 1'b0;
   logic resetn = 1'b0;
   logic prim_clk = 1'b0;
   logic alt_clk = 1'b0;
   logic force_ones = 1'b0;
   logic auto_ones = 1'b0;
   logic tx_lost = 1'b0;
   logic rx_lost = 1'b0;
   logic last_out = 1'b0;
   logic [8:0] cpu_addr;
   logic cpu_wr_en, cpu_rd_en, tx_clk_out, tx_use_alt_clk, tx_send_all_ones, shape_busy;
   logic ratio_1_15_sel, ext_term_sel, amp_reduced, pulse_short_t1, pulse_e1, pulse_long_t1;
   logic [7:0] cpu_wdata, cpu_rdata, build_out_atten;
   logic [1:0] build_out_sel;
   logic [2:0] pulse_template;
   logic [47:0] shape_coeffs;

   always #10 ref_clk = ~ref_clk;
   // line clocks unrelated to the master clock; the alternate one always runs
   always #324 prim_clk = ~prim_clk;
   always #244 alt_clk = ~alt_clk;

   tlc_host_model u_host (.ref_clk(ref_clk), .cpu_addr(cpu_addr), .cpu_wr_en(cpu_wr_en),
      .cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata), .cpu_rdata(cpu_rdata));

   tlc_top u_dut (.ref_clk(ref_clk), .resetn(resetn), .cpu_addr(cpu_addr),
      .cpu_wr_en(cpu_wr_en), .cpu_rd_en(cpu_rd_en), .cpu_wdata(cpu_wdata),
      .cpu_rdata(cpu_rdata), .force_all_ones_tx(force_ones),
      .auto_all_ones_on_rx_loss(auto_ones), .tx_clock_lost(tx_lost),
      .rx_signal_or_clock_lost(rx_lost), .primary_tx_line_clk(prim_clk),
      .alt_ref_line_clk(alt_clk), .tx_clk_out(tx_clk_out), .tx_use_alt_clk(tx_use_alt_clk),
      .tx_send_all_ones(tx_send_all_ones), .ratio_1_15_sel(ratio_1_15_sel),
      .ext_term_sel(ext_term_sel), .amp_reduced(amp_reduced), .build_out_sel(build_out_sel),
      .build_out_atten(build_out_atten), .pulse_template(pulse_template),
      .pulse_short_t1(pulse_short_t1), .pulse_e1(pulse_e1), .pulse_long_t1(pulse_long_t1),
      .shape_busy(shape_busy), .shape_coeffs(shape_coeffs));

   // run length of the selected clock; a runt is far below any half period
   always @(posedge ref_clk) begin
      if (!resetn) begin
         run_len <= 0;
      end else if (tx_clk_out !== last_out) begin
         if (run_len != 0) `CHK("clock run length", 1'b1, run_len >= 8)
         last_run <= run_len;
         run_len <= 1;
      end else if (run_len != 0) begin
         run_len <= run_len + 1;
      end
      last_out <= tx_clk_out;
   end

   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, errors);
      if (errors == 0 && samples_checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : results

   task automatic template_sweep();
      logic [7:0] cfg;
      logic [7:0] rd;
      logic [47:0] img;
      for (int t = 0; t < 8; t++) begin
         cfg = {t[0], t[1], t[1:0], t[2:0], 1'b0};
         img = ROM[48*t +: 48];
         u_host.write(TLC_CFG_ADDR, cfg, 1'b0);
         #1;
         `CHK("copy busy", 1'b1, shape_busy)
         repeat (TLC_COPY_CYCLES) @(posedge ref_clk);
         #1;
         `CHK("copy done", 1'b0, shape_busy)
         `CHK("shape image", img, shape_coeffs)
         u_host.read(TLC_SHAPE_BASE + 9'(t), rd);
         `CHK("shape register", {2'b00, img[6*t +: 6]}, rd)
         u_host.read(TLC_CFG_ADDR, rd);
         `CHK("config readback", cfg, rd)
         `CHK("ratio", cfg[7], ratio_1_15_sel)
         `CHK("termination", cfg[6], ext_term_sel)
         `CHK("reduced amplitude", cfg[7] & cfg[6], amp_reduced)
         `CHK("build-out", cfg[5:4], build_out_sel)
         `CHK("attenuation", (t == 7) ? TLC_LBO_STEP_TENTH_DB * {6'h00, cfg[5:4]} : 8'h00,
            build_out_atten)
         `CHK("template", cfg[3:1], pulse_template)
         `CHK("short class", t < 5, pulse_short_t1)
         `CHK("e1 class", t == 5 || t == 6, pulse_e1)
         `CHK("long class", t == 7, pulse_long_t1)
      end
      $display("test template_sweep done");
   endtask : template_sweep

   task automatic access_edges();
      logic [7:0] rd;
      u_host.write(TLC_SHAPE_BASE + 9'h003, 8'hFF, 1'b0);
      u_host.read(TLC_SHAPE_BASE + 9'h003, rd);
      `CHK("shape reserved bits", 8'h3F, rd)
      u_host.write(TLC_CFG_ADDR, 8'h0A, 1'b1);
      `CHK("shape reload", ROM[240 +: 48], shape_coeffs)
      // second write lands inside the copy on purpose
      u_host.write(TLC_CFG_ADDR, 8'h0C, 1'b0);
      u_host.write(TLC_CFG_ADDR, 8'h0E, 1'b1);
      u_host.read(TLC_CFG_ADDR, rd);
      `CHK("busy write dropped", 8'h0C, rd)
      `CHK("shape after drop", ROM[288 +: 48], shape_coeffs)
      u_host.write(9'h069, 8'h55, 1'b0);
      u_host.read(9'h069, rd);
      `CHK("unmapped read", 8'h00, rd)
      $display("test access_edges done");
   endtask : access_edges

   task automatic alarm_table();
      for (int a = 0; a < 2; a++) begin
         u_host.write(TLC_CFG_ADDR, {7'h00, a[0]}, 1'b1);
         for (int v = 0; v < 16; v++) begin
            @(posedge ref_clk);
            force_ones <= v[3];
            auto_ones <= v[2];
            tx_lost <= v[1];
            rx_lost <= v[0];
            repeat (5) @(posedge ref_clk);
            #1;
            `CHK("alt select", a[0] & (v[3] | v[1]), tx_use_alt_clk)
            `CHK("all ones", v[3] | (a[0] & v[1]) | (v[2] & v[0]), tx_send_all_ones)
         end
      end
      // half period of each source seen on the output; a switch may wait a full period
      repeat (200) @(posedge ref_clk);
      `CHK("alt clock width", 1'b1, last_run inside {[11:13]})
      force_ones <= 1'b0;
      tx_lost <= 1'b0;
      repeat (200) @(posedge ref_clk);
      `CHK("primary clock width", 1'b1, last_run inside {[15:17]})
      $display("test alarm_table done");
   endtask : alarm_table

   initial begin
      logic [7:0] rd;
      repeat (4) @(posedge ref_clk);
      resetn <= 1'b1;
      u_host.read(TLC_CFG_ADDR, rd);
      `CHK("config reset", TLC_CFG_RST, rd)
      `CHK("shapes reset", 48'h0, shape_coeffs)
      `CHK("alarm reset", 1'b0, tx_send_all_ones)
      $display("test reset done");
      template_sweep();
      access_edges();
      alarm_table();
      results();
   end

   // hang guard, far beyond the fewer than a thousand cycles the tests need
   initial begin
      repeat (20000) @(posedge ref_clk);
      errors++;
      results();
   end
endmodule : tlc_tb
`default_nettype wire
